// file: hdl/pwm_channel_timer.sv
// Purpose: One waveform channel: 8-bit counter, double-buffered period and duty, output.
// Assumes: Control bits and write strobes come from logic on i_ref_clk; the selected
//          channel clock is a one-cycle tick from the prescaler on the same clock.
// Notes:   Left-aligned and center-aligned modes; boundary values give constant levels.
`timescale 1ns/1ps

// How it works
// - Each channel owns an eight-bit counter, period register and duty register.
// - Setting enable drives the output at once; waveform waits for next clock cycle.
// - Enable is synchronised to the selected clock so it acts only on an edge.
// - Disabled counter with a nonzero period holds its value and resumes from it when re-enabled.
// - Polarity one starts high then low at duty; zero starts low then high.
// - While enabled, new period and duty wait for period end, counter write or disable.
// - While disabled, period and duty writes update buffer and active value together.
// - Counter is readable any time without disturbing the count.
// - Counter write clears it, sets direction up, loads buffers, restarts output level.
// - Disabled channel with zero period resets the counter on the next clock tick.
// - Counter write while enabled starts a new period at once per polarity.
// - Counter advances once per tick of the channel's selected clock.
// - Counter at or above active duty inverts the output flip-flop from the polarity level.
// - Cleared alignment bit selects left-aligned, up-only counting.
// - Left-aligned period match clears counter, resets output and loads buffers.
// - Left-aligned counter runs zero to period minus one.
// - Center-aligned counts up to period, down to zero, loading buffers at zero.
// - Zero period holds counter at zero; zero or large duty gives constant level.
module pwm_channel_timer
  import pwm_timer_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // Channel control
  input wire logic i_channel_enable,
  input wire logic i_start_level_bit,
  input wire logic i_center_align_bit,
  input wire logic i_sel_tick,
  // Software writes
  input wire wr_req_t i_wr,
  // Readback and waveform
  output status_t o_status,
  output logic o_wave,
  output logic o_wave_en
);

  // Buffered (software view) and active (compare) values
  logic [CNT_W-1:0] per_buf_q, per_buf_d;
  logic [CNT_W-1:0] duty_buf_q, duty_buf_d;
  logic [CNT_W-1:0] per_q, per_d;
  logic [CNT_W-1:0] duty_q, duty_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  dir_t dir_q, dir_d;
  logic wave_q, wave_d;
  logic wave_en_q;
  status_t status_q;

  // Gated tick
  logic run;
  logic tick_go;

  // Decoded conditions
  logic per_zero;
  logic left_end;
  logic ctr_top;
  logic ctr_bottom;
  logic ctr_load;
  logic [CNT_W-1:0] per_eff;
  logic [CNT_W-1:0] duty_eff;
  logic [CNT_W-1:0] cnt_step;
  logic flip;

  // Unsigned compare used for both the period end and the level decision
  function automatic logic at_or_above(input logic [CNT_W-1:0] a, input logic [CNT_W-1:0] b);
    at_or_above = (a >= b);
  endfunction : at_or_above

  pwm_tick_gate u_gate (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_channel_enable(i_channel_enable),
    .i_sel_tick(i_sel_tick),
    .o_run(run),
    .o_tick_go(tick_go)
  );

  // Buffer side: a write always lands in the buffer, readback shows it
  assign per_buf_d = i_wr.period_wr ? i_wr.period_data : per_buf_q;
  assign duty_buf_d = i_wr.duty_wr ? i_wr.duty_data : duty_buf_q;

  // End-of-cycle detection for both alignments
  assign per_zero = (per_q == CNT_ZERO);
  assign left_end = at_or_above(cnt_q + CNT_ONE, per_q);
  assign ctr_top = at_or_above(cnt_q, per_q);
  // Zero is reached either stepping down from one, or turning at a period of one;
  // missing the second case would step down past zero and wrap to the top
  assign ctr_bottom = (cnt_q <= CNT_ONE) && ((dir_q == DIR_DOWN) || ctr_top);
  assign cnt_step = (dir_q == DIR_UP) ? cnt_q + CNT_ONE : cnt_q - CNT_ONE;

  // Active values reload: counter write, disabled channel, or end of period
  assign ctr_load = i_wr.counter_wr
    || !i_channel_enable
    || (tick_go && !i_center_align_bit && left_end)
    || (tick_go && i_center_align_bit && ctr_bottom);
  assign per_eff = (i_wr.period_wr && !i_channel_enable) ? i_wr.period_data : per_buf_q;
  assign duty_eff = (i_wr.duty_wr && !i_channel_enable) ? i_wr.duty_data : duty_buf_q;
  assign per_d = ctr_load ? per_eff : per_q;
  assign duty_d = ctr_load ? duty_eff : duty_q;

  // Counter next state
  always_comb begin
    cnt_d = cnt_q;
    dir_d = dir_q;
    if (i_wr.counter_wr) begin
      cnt_d = CNT_ZERO;
      dir_d = DIR_UP;
    end else if (i_sel_tick && !run && per_zero) begin
      cnt_d = CNT_ZERO;
    end else if (tick_go) begin
      if (per_zero) begin
        cnt_d = CNT_ZERO;
        dir_d = DIR_UP;
      end else if (!i_center_align_bit) begin
        dir_d = DIR_UP;
        cnt_d = left_end ? CNT_ZERO : cnt_q + CNT_ONE;
      end else if (dir_q == DIR_UP && ctr_top) begin
        dir_d = ctr_bottom ? DIR_UP : DIR_DOWN;
        cnt_d = cnt_q - CNT_ONE;
      end else begin
        cnt_d = cnt_step;
        if (ctr_bottom) begin
          dir_d = DIR_UP;
        end
      end
    end
  end

  // Output flip-flop state follows the duty match; the boundary values pin it.
  // Deriving it from the next count keeps the level and count in step after a
  // counter write, at the cost of a comparator in the output path.
  assign flip = !(per_d == CNT_ZERO)
    && !at_or_above(duty_d, per_d)
    && at_or_above(cnt_d, duty_d);
  assign wave_d = i_start_level_bit ^ flip;

  // Storage
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      per_buf_q <= PERIOD_RST;
      duty_buf_q <= DUTY_RST;
      per_q <= PERIOD_RST;
      duty_q <= DUTY_RST;
    end else begin
      per_buf_q <= per_buf_d;
      duty_buf_q <= duty_buf_d;
      per_q <= per_d;
      duty_q <= duty_d;
    end
  end

  // Counter, direction and waveform; a stopped channel keeps its count unless its period is zero
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_q <= CNT_ZERO;
      dir_q <= DIR_UP;
      wave_q <= 1'b0;
      wave_en_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      dir_q <= dir_d;
      wave_q <= wave_d;
      wave_en_q <= i_channel_enable;
    end
  end

  // Readback register; reading has no side effect on the count
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      status_q <= '{CNT_ZERO, PERIOD_RST, DUTY_RST, DIR_UP};
    end else begin
      status_q <= '{cnt_d, per_buf_d, duty_buf_d, dir_d};
    end
  end

  assign o_status = status_q;
  assign o_wave = wave_q;
  assign o_wave_en = wave_en_q;

  // Checks on the behaviour above

  AST_CNT_WRITE_CLEARS: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    i_wr.counter_wr |=> (cnt_q == CNT_ZERO) && (dir_q == DIR_UP)
  ) else $error("counter write did not clear counter and set direction up");

  AST_CNT_WRITE_LOADS: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    i_wr.counter_wr && !i_wr.period_wr |=> per_q == $past(per_buf_q)
  ) else $error("counter write did not load the buffered period");

  AST_HOLD_WHEN_STOPPED: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    !run && !i_wr.counter_wr && !(i_sel_tick && per_zero) |=> cnt_q == $past(cnt_q)
  ) else $error("counter moved while the channel was stopped");

  AST_NO_TICK_NO_COUNT: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    !i_sel_tick && !i_wr.counter_wr |=> $stable(cnt_q)
  ) else $error("counter changed without a selected clock tick");

  AST_ENABLED_BUFFERED: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    i_channel_enable && !tick_go && !i_wr.counter_wr |=> $stable(per_q) && $stable(duty_q)
  ) else $error("active period or duty changed mid period");

  AST_DISABLED_DIRECT: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    !i_channel_enable && i_wr.duty_wr |=> duty_q == $past(i_wr.duty_data)
  ) else $error("duty write while disabled did not reach the active value");

  AST_LEFT_WRAP: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    tick_go && !i_center_align_bit && !per_zero && (cnt_q + CNT_ONE == per_q)
      && !i_wr.counter_wr |=> cnt_q == CNT_ZERO
  ) else $error("left-aligned counter did not wrap at period minus one");

  AST_LEFT_STEP: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    tick_go && !i_center_align_bit && !left_end && !i_wr.counter_wr
      |=> cnt_q == $past(cnt_q) + CNT_ONE
  ) else $error("left-aligned counter did not count up by one");

  AST_START_LEVEL: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    i_wr.counter_wr && !i_wr.duty_wr && !i_wr.period_wr && (duty_buf_q != CNT_ZERO)
      ##1 $stable(i_start_level_bit) |-> o_wave == $past(i_start_level_bit)
  ) else $error("output did not restart at the polarity level");

  AST_ZERO_PERIOD: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    per_zero && tick_go |=> cnt_q == CNT_ZERO
  ) else $error("zero period did not hold the counter at zero");

  AST_ZERO_PERIOD_LEVEL: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    per_d == CNT_ZERO |=> o_wave == $past(i_start_level_bit)
  ) else $error("zero period did not hold the polarity level");

  AST_DUTY_HOLDS_LEVEL: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    at_or_above(duty_d, per_d) |=> o_wave == $past(i_start_level_bit)
  ) else $error("duty not below period did not hold the polarity level");

  AST_CENTER_TURN: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    tick_go && i_center_align_bit && !per_zero && dir_q == DIR_UP && cnt_q == per_q
      && !ctr_bottom && !i_wr.counter_wr |=> dir_q == DIR_DOWN
  ) else $error("center-aligned counter did not turn at the period");

  AST_CENTER_BOTTOM: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    tick_go && i_center_align_bit && !per_zero && ctr_bottom && !i_wr.counter_wr
      |=> (cnt_q == CNT_ZERO) && (dir_q == DIR_UP)
  ) else $error("center-aligned counter did not turn up at zero");

  AST_CENTER_STEP_DOWN: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    tick_go && i_center_align_bit && !per_zero && dir_q == DIR_DOWN && !ctr_bottom
      && !i_wr.counter_wr |=> (cnt_q == $past(cnt_q) - CNT_ONE) && (dir_q == DIR_DOWN)
  ) else $error("center-aligned counter did not count down by one");

  AST_LEFT_UP_ONLY: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    tick_go && !i_center_align_bit && !i_wr.counter_wr |=> dir_q == DIR_UP
  ) else $error("left-aligned counter left the up direction");

  AST_CNT_WRITE_DUTY: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    i_wr.counter_wr && !i_wr.duty_wr |=> duty_q == $past(duty_buf_q)
  ) else $error("counter write did not load the buffered duty");

  AST_DISABLED_PERIOD: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    !i_channel_enable && i_wr.period_wr |=> per_q == $past(i_wr.period_data)
  ) else $error("period write while disabled did not reach the active value");

  AST_DUTY_MATCH: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    tick_go && i_channel_enable && !i_center_align_bit && !i_wr.counter_wr && !left_end
      && (cnt_q + CNT_ONE == duty_q) && !at_or_above(duty_q, per_q)
      |=> o_wave == !$past(i_start_level_bit)
  ) else $error("output did not change level at the duty match");

  AST_RUN_FOLLOWS: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    i_sel_tick |=> run == $past(i_channel_enable)
  ) else $error("channel gate did not take the enable at a clock edge");

  AST_OUT_DISABLE: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    !i_channel_enable |=> !o_wave_en
  ) else $error("output enable stayed on after the enable bit dropped");

  AST_ENABLE_AT_EDGE: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    !i_sel_tick |=> $stable(run)
  ) else $error("channel gate changed away from a clock edge");

  AST_OUT_ENABLE: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    i_channel_enable |=> o_wave_en
  ) else $error("output enable did not follow the enable bit");

endmodule : pwm_channel_timer

// file: hdl/pwm_tick_gate.sv
// Purpose: Edge synchroniser that gates the selected channel clock with the enable bit.
// Assumes: i_sel_tick is a one-cycle pulse on i_ref_clk marking each selected clock edge.
// Notes:   Enable and disable take effect only at a tick, never in mid-cycle.
`timescale 1ns/1ps
module pwm_tick_gate
  import pwm_timer_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // Control
  input wire logic i_channel_enable,
  input wire logic i_sel_tick,
  // Gated result
  output logic o_run,
  output logic o_tick_go
);

  logic run_q;

  // Run state follows the enable only at a selected clock edge
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      run_q <= 1'b0;
    end else if (i_sel_tick) begin
      run_q <= i_channel_enable;
    end
  end

  // A tick counts only once the channel was already running, so the waveform
  // begins on the selected clock cycle after the one that saw the enable
  assign o_run = run_q;
  assign o_tick_go = i_sel_tick & run_q;

endmodule : pwm_tick_gate

// file: hdl/pwm_timer_pkg.sv
// Purpose: Shared widths, constants and carrier types for the waveform channel timer.
// Assumes: One reference clock; the selected channel clock arrives as a one-cycle tick.
// Notes:   Every number used by the logic is named here.
package pwm_timer_pkg;

  // Counter, period and duty width
  localparam int CNT_W = 8;

  // Counter constants
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

  // Reset values of the period and duty storage
  localparam logic [CNT_W-1:0] PERIOD_RST = 8'h00;
  localparam logic [CNT_W-1:0] DUTY_RST = 8'h00;

  // Counting direction; one bit so the usual path is Gray by nature
  typedef enum logic [0:0] {
    DIR_UP = 1'b0,
    DIR_DOWN = 1'b1
  } dir_t;

  // Software write strobes with their data
  typedef struct packed {
    logic period_wr;
    logic [CNT_W-1:0] period_data;
    logic duty_wr;
    logic [CNT_W-1:0] duty_data;
    logic counter_wr;
  } wr_req_t;

  // Readback of the channel state
  typedef struct packed {
    logic [CNT_W-1:0] channel_counter;
    logic [CNT_W-1:0] period_value;
    logic [CNT_W-1:0] duty_value;
    dir_t dir;
  } status_t;

endpackage : pwm_timer_pkg

// file: tb/pwm_channel_timer_tb.sv
// Purpose: Self-checking bench for one waveform channel against a cycle model.
// Assumes: Both alignments; inputs change 1 ns after the rising edge.
// Notes:   Model tracks counter, active and buffered period and duty each edge.
`timescale 1ns/1ps
module pwm_channel_timer_tb;
  import pwm_timer_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, en = 1'b0, pol = 1'b0, tick = 1'b0, clr = 1'b0;
  wr_req_t wr = '0;
  status_t st;
  logic wave, wave_en;
  logic [7:0] rises;
  logic [7:0] mc, nc, pa, da, pb, db;
  logic run, mpol, men, md, ld, cae = 1'b0;
  logic [15:0] ob;
  int fails = 0, checks_done = 0;

  always #10 clk = !clk;

  pwm_channel_timer DUT (.i_ref_clk(clk), .i_rstn(rstn), .i_channel_enable(en),
    .i_start_level_bit(pol), .i_center_align_bit(cae), .i_sel_tick(tick),
    .i_wr(wr), .o_status(st), .o_wave(wave), .o_wave_en(wave_en));
  pwm_wave_monitor mon (.i_ref_clk(clk), .i_rstn(rstn), .i_wave(wave),
    .i_wave_en(wave_en), .i_clear(clr), .o_rises(rises));

  task check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Level from count against active values; period 0 or big duty is constant
  function logic exp_wave(input logic [7:0] c, d, p, input logic pl);
    if (p == 8'h00 || d >= p) return pl;
    return (c < d) ? pl : !pl;
  endfunction : exp_wave

  // Cycle model; counter write wins over a tick in the same cycle
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {mc, pa, da, pb, db, run, mpol, men, md} = '0;
    end else begin
      nc = mc;
      // Period end: left wraps before the period, center turns up at zero
      ld = wr.counter_wr;
      if (tick && run && cae) ld = ld || (mc <= 8'h01 && (md || mc >= pa));
      if (tick && run && !cae) ld = ld || (8'(mc + 8'h01) >= pa);
      if (wr.counter_wr) begin
        nc = 8'h00;
        md = 1'b0;
      end else if (tick && !run && pa == 8'h00) begin
        nc = 8'h00;
      end else if (tick && run) begin
        if (pa == 8'h00) begin
          nc = 8'h00;
          md = 1'b0;
        end else if (!cae) begin
          md = 1'b0;
          nc = 8'(mc + 8'h01);
          if (nc >= pa) nc = 8'h00;
        end else if (!md && mc >= pa) begin
          nc = mc - 8'h01;
          md = mc > 8'h01;
        end else begin
          nc = md ? mc - 8'h01 : mc + 8'h01;
          if (md && mc <= 8'h01) md = 1'b0;
        end
      end
      // Enabled: loads take the old buffer; disabled: writes go straight through
      ob = {pb, db};
      if (wr.period_wr) pb = wr.period_data;
      if (wr.duty_wr) db = wr.duty_data;
      if (!en) ob = {pb, db};
      if (ld || !en) {pa, da} = ob;
      if (tick) run = en;
      mc = nc;
      mpol = pol;
      men = en;
    end
  end

  // Compare between edges, where every registered output has settled
  always @(negedge clk) begin
    if (rstn) begin
      check(st.channel_counter, mc);
      check({7'h00, wave}, {7'h00, exp_wave(mc, da, pa, mpol)});
      check({7'h00, wave_en}, {7'h00, men});
      check(st.period_value, pb);
      check(st.duty_value, db);
      check({7'h00, st.dir}, {7'h00, md});
    end
  end

  task ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      #1 tick = 1'b1;
      @(posedge clk);
      #1 tick = 1'b0;
      @(posedge clk);
    end
  endtask : ticks

  task results;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results

  // Watchdog, well beyond the expected run of about 6100 cycles
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    results();
  end

  initial begin
    void'($urandom(32'hcaada1e0));
    repeat (4) @(posedge clk);
    #1 rstn = 1'b1;
    // Walk: period 4, duty 1, start low; counter written before enable
    @(posedge clk);
    #1 wr = '{period_wr: 1'b1, period_data: 8'h04, duty_wr: 1'b1, duty_data: 8'h01,
      counter_wr: 1'b0};
    @(posedge clk);
    #1 wr = '{counter_wr: 1'b1, default: '0};
    clr = 1'b1;
    @(posedge clk);
    #1 wr = '0;
    clr = 1'b0;
    en = 1'b1;
    ticks(21);
    #1 check(rises, 8'h05);
    $display("test walk done");
    // Random traffic in each alignment with boundary periods and duties mixed in;
    // the mode only changes while the channel is stopped and its counter written
    for (int m = 0; m < 2; m++) begin
      @(posedge clk);
      #1 wr = '0;
      tick = 1'b0;
      en = 1'b0;
      ticks(2);
      #1 cae = (m == 1);
      wr = '{counter_wr: 1'b1, default: '0};
      @(posedge clk);
      #1 wr = '0;
      en = 1'b1;
      for (int i = 0; i < 3000; i++) begin
        @(posedge clk);
        #1 tick = ($urandom % 3) == 0;
        wr = '{period_wr: ($urandom % 50) == 0, period_data: 8'($urandom % 9),
          duty_wr: ($urandom % 40) == 0, duty_data: 8'($urandom % 10),
          counter_wr: ($urandom % 90) == 0};
        if (($urandom % 120) == 0) en = !en;
        if (($urandom % 200) == 0) pol = !pol;
      end
      $display("test random mode %0d done", m);
    end
    results();
  end
endmodule : pwm_channel_timer_tb

// file: tb/pwm_wave_monitor.sv
// Purpose: Load on the waveform pin; counts rising edges while the pin is driven.
// Assumes: Sampled on the reference clock; the waveform is registered there.
// Notes:   Only observes, so it can never disturb the channel.
`timescale 1ns/1ps
module pwm_wave_monitor (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // Pin side
  input wire logic i_wave,
  input wire logic i_wave_en,
  input wire logic i_clear,
  // Edge count
  output logic [7:0] o_rises
);
  logic last_q;

  // Edge counter; an undriven pin is ignored since its level means nothing
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      last_q <= 1'b0;
      o_rises <= 8'h00;
    end else begin
      last_q <= i_wave;
      if (i_clear) o_rises <= 8'h00;
      else if (i_wave_en && i_wave && !last_q) o_rises <= o_rises + 8'h01;
    end
  end
endmodule : pwm_wave_monitor
